/* File: design/ilc_pkg.sv */
// package: register map, field layout and timing constants of the input line conditioner
package ilc_pkg;
    localparam int unsigned NUM_LINES       = 3;
    localparam int unsigned DEB_W           = 20;
    localparam logic [11:0] OFF_CHOICE      = 12'h000;
    localparam logic [11:0] OFF_DEBOUNCE    = 12'h004;
    localparam logic [11:0] OFF_POLARITY    = 12'h008;
    localparam logic [11:0] OFF_TERM        = 12'h00C;
    localparam logic [11:0] OFF_STATUS      = 12'h010;
    localparam int unsigned STAT_RAW_POS    = 0;
    localparam int unsigned STAT_CLEAN_POS  = 4;
    localparam int unsigned STAT_OUT_POS    = 8;
    localparam logic [1:0]  RST_CHOICE      = 2'h0;
    localparam logic [DEB_W-1:0] RST_DEBOUNCE = 20'h0_0000;
    localparam logic        RST_POLARITY    = 1'b0;
    localparam logic        RST_TERM        = 1'b0;
    localparam logic [DEB_W-1:0] MAX_DEBOUNCE = 20'hF_4240;
    localparam int unsigned CLK_MHZ         = 40;
    localparam int unsigned TICK_US         = 1;
    localparam int unsigned CYC_PER_US      = CLK_MHZ * TICK_US;
    localparam logic [5:0]  US_PRESCALE_MAX = 6'(CYC_PER_US - 1);
endpackage : ilc_pkg

/* File: design/ilc_debounce.sv */
// module: one debounce filter with its own microsecond counter
module ilc_debounce (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ce_i,
    input  wire logic                       us_tick_i,
    input  wire logic                       raw_i,
    input  wire logic [ilc_pkg::DEB_W-1:0]  time_us_i,
    output logic                            clean_o
);
    logic                      clean_r;
    logic                      last_r;
    logic [ilc_pkg::DEB_W-1:0] cnt_r;
    wire changed   = raw_i != last_r;
    wire differs   = raw_i != clean_r;
    // the free-running prescaler may tick right after a change, so one extra tick
    // guarantees the level held for at least the full programmed time
    wire reached   = (cnt_r > time_us_i);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clean_r <= 1'b0;
            last_r  <= 1'b0;
            cnt_r   <= '0;
        end else if (ce_i) begin
            last_r <= raw_i;
            if (changed || !differs) begin
                cnt_r <= '0;
            end else if (reached) begin
                clean_r <= raw_i;
                cnt_r   <= '0;
            end else if (us_tick_i) begin
                cnt_r <= cnt_r + 1'b1;
            end
            // zero duration passes the level straight through
            if (time_us_i == '0) begin
                clean_r <= raw_i;
            end
        end
    end
    assign clean_o = clean_r;
endmodule : ilc_debounce

/* File: design/ilc_top.sv */
// module: three input line conditioners behind an AHB-Lite register slave
module ilc_top (
    input  wire logic                            clk_i,
    input  wire logic                            rst_n_i,
    input  wire logic                            ce_i,
    input  wire logic                            hsel_i,
    input  wire logic [31:0]                     haddr_i,
    input  wire logic [1:0]                      htrans_i,
    input  wire logic                            hwrite_i,
    input  wire logic [2:0]                      hsize_i,
    input  wire logic [31:0]                     hwdata_i,
    input  wire logic                            hready_i,
    output logic [31:0]                          hrdata_o,
    output logic                                 hreadyout_o,
    output logic                                 hresp_o,
    input  wire logic [ilc_pkg::NUM_LINES-1:0]   line_raw_i,
    output logic [ilc_pkg::NUM_LINES-1:0]        line_out_o,
    output logic [ilc_pkg::NUM_LINES-1:0]        term_resistor_on_o
);
    localparam int unsigned N = ilc_pkg::NUM_LINES;

    logic [1:0]                input_choice_r;
    logic [ilc_pkg::DEB_W-1:0] debounce_time_us_r [N];
    logic [N-1:0]              polarity_flip_r;
    logic [N-1:0]              term_resistor_on_r;
    logic [N-1:0]              line_out_r;
    logic [N-1:0]              clean;
    logic [5:0]                pre_r;
    logic                      wr_pend_r;
    logic [11:0]               wr_addr_r;
    logic [31:0]               hrdata_r;

    // address phase decode; data phase completes in one cycle, no wait states
    wire        ap_valid   = hsel_i && hready_i && htrans_i[1];
    wire        ap_read    = ap_valid && !hwrite_i;
    wire [11:0] ap_addr    = {haddr_i[11:2], 2'b00};
    wire        sel_ok     = input_choice_r < 2'(N);
    wire        do_write   = wr_pend_r && sel_ok;
    wire        wr_choice  = wr_pend_r && (wr_addr_r == ilc_pkg::OFF_CHOICE);
    wire        wr_deb     = do_write && (wr_addr_r == ilc_pkg::OFF_DEBOUNCE);
    wire        wr_pol     = do_write && (wr_addr_r == ilc_pkg::OFF_POLARITY);
    wire        wr_term    = do_write && (wr_addr_r == ilc_pkg::OFF_TERM);
    wire [ilc_pkg::DEB_W-1:0] deb_in = (hwdata_i[ilc_pkg::DEB_W-1:0] > ilc_pkg::MAX_DEBOUNCE)
                                       ? ilc_pkg::MAX_DEBOUNCE : hwdata_i[ilc_pkg::DEB_W-1:0];
    wire        us_tick    = (pre_r == ilc_pkg::US_PRESCALE_MAX);
    wire [1:0]  idx        = sel_ok ? input_choice_r : 2'h0;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ap_addr)
            ilc_pkg::OFF_CHOICE:   rd_mux = {30'h0000_0000, input_choice_r};
            ilc_pkg::OFF_DEBOUNCE: rd_mux = sel_ok ? {12'h000, debounce_time_us_r[idx]} : 32'h0000_0000;
            ilc_pkg::OFF_POLARITY: rd_mux = {31'h0000_0000, sel_ok && polarity_flip_r[idx]};
            ilc_pkg::OFF_TERM:     rd_mux = {31'h0000_0000, sel_ok && term_resistor_on_r[idx]};
            ilc_pkg::OFF_STATUS: begin
                rd_mux[ilc_pkg::STAT_RAW_POS   +: N] = line_raw_i;
                rd_mux[ilc_pkg::STAT_CLEAN_POS +: N] = clean;
                rd_mux[ilc_pkg::STAT_OUT_POS   +: N] = line_out_r;
            end
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_r  <= 32'h0000_0000;
            pre_r     <= 6'h00;
        end else if (ce_i) begin
            wr_pend_r <= ap_valid && hwrite_i;
            if (ap_valid) begin
                wr_addr_r <= ap_addr;
            end
            if (ap_read) begin
                hrdata_r <= rd_mux;
            end
            pre_r <= us_tick ? 6'h00 : pre_r + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            input_choice_r <= ilc_pkg::RST_CHOICE;
        end else if (ce_i && wr_choice) begin
            input_choice_r <= hwdata_i[1:0];
        end
    end

    // per-line settings: only the selected line's slot is written
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_line
            wire hit = (input_choice_r == 2'(g));
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    debounce_time_us_r[g] <= ilc_pkg::RST_DEBOUNCE;
                    polarity_flip_r[g]    <= ilc_pkg::RST_POLARITY;
                    term_resistor_on_r[g] <= ilc_pkg::RST_TERM;
                    line_out_r[g]         <= 1'b0;
                end else if (ce_i) begin
                    if (wr_deb && hit) begin
                        debounce_time_us_r[g] <= deb_in;
                    end
                    if (wr_pol && hit) begin
                        polarity_flip_r[g] <= hwdata_i[0];
                    end
                    if (wr_term && hit) begin
                        term_resistor_on_r[g] <= hwdata_i[0];
                    end
                    line_out_r[g] <= clean[g] ^ polarity_flip_r[g];
                end
            end
            ilc_debounce u_deb (
                .clk_i     (clk_i),
                .rst_n_i   (rst_n_i),
                .ce_i      (ce_i),
                .us_tick_i (us_tick),
                .raw_i     (line_raw_i[g]),
                .time_us_i (debounce_time_us_r[g]),
                .clean_o   (clean[g])
            );
        end
    endgenerate

    assign hrdata_o           = hrdata_r;
    assign hreadyout_o        = 1'b1;
    assign hresp_o            = 1'b0;
    assign line_out_o         = line_out_r;
    assign term_resistor_on_o = term_resistor_on_r;
endmodule : ilc_top

/* File: verification/ilc_checker.sv */
// checker: bus and line output relations at the ports of ilc_top
module ilc_checker (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic        hsel_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [2:0]  line_out_o,
    input wire logic [2:0]  term_resistor_on_o
);
    wire wr_take = hsel_i & htrans_i[1] & hready_i & ce_i & hwrite_i;
    wire rd_take = hsel_i & htrans_i[1] & hready_i & ce_i & !hwrite_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ready_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus stalled or erred");
    reset_out_a: assert property ($rose(rst_n_i) |-> line_out_o == '0 && hrdata_o == '0)
        else $error("outputs not cleared");
    reset_term_a: assert property ($rose(rst_n_i) |-> term_resistor_on_o == '0) else $error("term not cleared");
    term_cause_a: assert property ($past(rst_n_i) && $changed(term_resistor_on_o) |-> $past(wr_take, 2))
        else $error("term moved without write");
    term_single_a: assert property ($past(rst_n_i) |-> $countones(term_resistor_on_o ^ $past(term_resistor_on_o)) <= 1)
        else $error("two term bits moved");
    rdata_hold_a: assert property ($past(rst_n_i) && $changed(hrdata_o) |-> $past(rd_take))
        else $error("read data moved without read");
    freeze_a: assert property (!ce_i |=> $stable({line_out_o, term_resistor_on_o, hrdata_o}))
        else $error("state moved while disabled");
    high_zero_a: assert property (hrdata_o[31:20] == '0) else $error("read data high bits set");
    cover property (wr_take);
    cover property (rd_take);
    cover property ($changed(line_out_o));
endmodule : ilc_checker

/* File: verification/ilc_trig_src.sv */
// partner: external trigger source driving the three raw lines
module ilc_trig_src (
    input  wire logic       clk_i,
    output logic [2:0]      line_raw_o
);
    initial line_raw_o = 3'h0;
    // flips line k for cyc clocks; width chosen by the caller against the debounce time
    task automatic pulse(input int k, input int cyc);
        @(posedge clk_i);
        line_raw_o[k] <= ~line_raw_o[k];
        repeat (cyc) @(posedge clk_i);
        line_raw_o[k] <= ~line_raw_o[k];
    endtask : pulse
endmodule : ilc_trig_src

/* File: verification/ilc_tb.sv */
// testbench: register access over AHB-Lite and line conditioning
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i    = 1'b0;
    logic        rst_n_i  = 1'b0;
    logic        ce_i     = 1'b1;
    logic        hsel_i   = 1'b0;
    logic [31:0] haddr_i  = 32'h0000_0000;
    logic [1:0]  htrans_i = 2'h0;
    logic        hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [31:0] hrdata_o, rd;
    logic        hreadyout_o, hresp_o;
    logic [2:0]  line_raw_i, line_out_o, term_resistor_on_o;
    int          miscompares = 0;
    int          cmp_count = 0;
    always #12.5 clk_i = ~clk_i;
    ilc_top ilc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .line_raw_i(line_raw_i),
        .line_out_o(line_out_o), .term_resistor_on_o(term_resistor_on_o));
    ilc_trig_src ilc_trig_src_i (.clk_i(clk_i), .line_raw_o(line_raw_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        haddr_i <= {20'h0_0000, off};
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : bus
    task automatic rd_chk(input logic [11:0] off, input logic [31:0] exp);
        bus(1'b0, off, 32'h0000_0000);
        chk(rd, exp);
    endtask : rd_chk
    task automatic t_reset;
        rd_chk(ilc_pkg::OFF_CHOICE, 32'h0000_0000);
        rd_chk(ilc_pkg::OFF_DEBOUNCE, 32'h0000_0000);
        rd_chk(ilc_pkg::OFF_POLARITY, 32'h0000_0000);
        rd_chk(12'h020, 32'h0000_0000);
    endtask : t_reset
    task automatic t_term;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, ilc_pkg::OFF_CHOICE, 32'(k));
            bus(1'b1, ilc_pkg::OFF_TERM, 32'h0000_0001);
            rd_chk(ilc_pkg::OFF_TERM, 32'(k < 3));
            chk(32'(term_resistor_on_o), 32'(3'((4'h2 << k) - 4'h1)));
        end
    endtask : t_term
    task automatic t_pol;
        bus(1'b1, ilc_pkg::OFF_CHOICE, 32'h0000_0001);
        bus(1'b1, ilc_pkg::OFF_POLARITY, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        chk(32'(line_out_o), 32'h0000_0002);
        rd_chk(ilc_pkg::OFF_STATUS, 32'h0000_0200);
        bus(1'b1, ilc_pkg::OFF_POLARITY, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        chk(32'(line_out_o), 32'h0000_0000);
    endtask : t_pol
    task automatic t_deb;
        bus(1'b1, ilc_pkg::OFF_DEBOUNCE, 32'h000F_FFFF);
        rd_chk(ilc_pkg::OFF_DEBOUNCE, 32'h000F_4240);
        bus(1'b1, ilc_pkg::OFF_CHOICE, 32'h0000_0002);
        bus(1'b1, ilc_pkg::OFF_DEBOUNCE, 32'h0000_0003);
        // glitch just under 3 us: line 0 has no filter, line 2 must reject it
        fork
            ilc_trig_src_i.pulse(0, 80);
            ilc_trig_src_i.pulse(2, 115);
            begin repeat (60) @(posedge clk_i); chk(32'(line_out_o), 32'h0000_0001); end
        join
        fork
            ilc_trig_src_i.pulse(2, 200);
            begin repeat (190) @(posedge clk_i); chk(32'(line_out_o), 32'h0000_0004); end
        join
        repeat (170) @(posedge clk_i);
        chk(32'(line_out_o), 32'h0000_0000);
    endtask : t_deb
    task automatic give_verdict;
        if (miscompares == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset;
        t_term;
        t_pol;
        t_deb;
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b1;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        give_verdict;
    end
endmodule : tb
bind ilc_top ilc_checker ilc_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .line_out_o(line_out_o),
    .term_resistor_on_o(term_resistor_on_o));
